// File: design/cies_defs.vh
// constants of the cpu interrupt entry sequencer
// Contract
// - reset and each source own a low vector
// - lower vector address wins, reset first
// - source fires only with own and global enable
// - accepting interrupt clears global enable
// - global enable inside handler allows nesting
// - return instruction sets global enable
// - vectoring clears served source's pending flag
// - writing one clears flag, zero keeps
// - disabled source's flag stays until served/cleared
// - flags wait for global enable, priority order
// - level sources request only while present
// - one main instruction after return
// - status flags never saved nor restored
// - global disable acts in same cycle
// - instruction after global enable completes first
// - entry takes four cycles then vector
// - program counter pushed during entry
// - multi-cycle instruction finishes before entry
// - wake from sleep adds four cycles
// - return: four cycles, pop two, enable
// - register alu operation completes in one cycle
// - core clock undivided from chip source
// - nine bit counter, vectors inside 512 words
// - push of return address lowers pointer two
`ifndef CIES_DEFS_VH
`define CIES_DEFS_VH

// widths
`define CIES_PC_W          9
`define CIES_NSRC          8
`define CIES_SP_W          8
`define CIES_ADDR_W        8

// vector layout: reset at word zero, source n at word n+1
`define CIES_RESET_VEC     9'h000
`define CIES_SRC_VEC_BASE  9'h001

// sources 4..7 are level type, 0..3 keep a pending flag
`define CIES_LEVEL_MASK    8'hF0

// timing counts in core clock cycles
`define CIES_ENTRY_CYC     4'h4
`define CIES_SLEEP_EXTRA   4'h4
`define CIES_RETURN_CYC    4'h4

// register offsets (byte addresses)
`define CIES_OFF_CTRL      8'h00
`define CIES_OFF_ENABLE    8'h04
`define CIES_OFF_FLAGS     8'h08
`define CIES_OFF_LEVEL     8'h0C
`define CIES_OFF_SP        8'h10
`define CIES_OFF_STATUS    8'h14

// control field and reset values
`define CIES_CTRL_GIE_BIT  0
`define CIES_SP_RST        8'h9F
`define CIES_ENABLE_RST    8'h00

// sequencer states
`define CIES_ST_IDLE       2'h0
`define CIES_ST_ENTRY      2'h1
`define CIES_ST_RETURN     2'h2

`endif

// File: design/cies_sequencer.v
// interrupt entry and return sequencer for the 8-bit core
`timescale 1ns/1ps
`include "cies_defs.vh"

module cies_sequencer (
    input  wire                       core_clk_i,
    input  wire                       arst_n_i,
    // register port
    input  wire [`CIES_ADDR_W-1:0]    reg_addr_i,
    input  wire [31:0]                reg_wdata_i,
    input  wire                       reg_wr_i,
    input  wire                       reg_rd_i,
    output reg  [31:0]                reg_rdata_o,
    // interrupt sources
    input  wire [`CIES_NSRC-1:0]      src_event_i,
    input  wire [`CIES_NSRC-1:0]      src_level_i,
    output reg  [`CIES_NSRC-1:0]      src_ack_o,
    // instruction sequencer side
    input  wire                       insn_done_i,
    input  wire                       insn_sei_i,
    input  wire                       insn_cli_i,
    input  wire                       return_from_interrupt_instruction_start_i,
    input  wire                       sleep_i,
    input  wire                       wake_ready_i,
    input  wire [`CIES_PC_W-1:0]      pc_return_i,
    output wire                       seq_busy_o,
    output reg                        pc_load_o,
    output reg  [`CIES_PC_W-1:0]      pc_target_o,
    output reg                        global_irq_enable_o,
    // stack port into data memory
    output reg                        stack_we_o,
    output reg                        stack_re_o,
    output reg  [`CIES_SP_W-1:0]      stack_addr_o,
    output reg  [7:0]                 stack_wdata_o,
    input  wire [7:0]                 stack_rdata_i
);

    // lowest set index wins; index 0 sits on the lowest source vector
    function [2:0] pick_lowest;
        input [`CIES_NSRC-1:0] req;
        integer k;
        begin
            pick_lowest = 3'd0;
            for (k = `CIES_NSRC - 1; k >= 0; k = k - 1) begin
                if (req[k]) begin
                    pick_lowest = k[2:0];
                end
            end
        end
    endfunction

    // program vector of a source, always inside the 512 word space
    function [`CIES_PC_W-1:0] vector_of;
        input [2:0] idx;
        begin
            vector_of = `CIES_SRC_VEC_BASE + {6'h00, idx};
        end
    endfunction

    // one-hot of an index
    function [`CIES_NSRC-1:0] onehot;
        input [2:0] idx;
        begin
            onehot = {{(`CIES_NSRC-1){1'b0}}, 1'b1} << idx;
        end
    endfunction

    reg  [1:0]               state_reg;
    reg  [3:0]               cnt_reg;
    reg  [3:0]               len_reg;
    reg  [`CIES_NSRC-1:0]    enable_reg;
    reg  [`CIES_NSRC-1:0]    flags_reg;
    reg  [`CIES_NSRC-1:0]    flags_next;
    reg  [`CIES_SP_W-1:0]    sp_reg;
    reg                      gie_reg;
    reg                      ret_shadow_reg;
    reg                      hi_reg;
    reg  [`CIES_PC_W-1:0]    vec_reg;
    reg  [2:0]               last_src_reg;

    wire                     idle;
    wire                     cli_now;
    wire                     sei_now;
    wire                     gie_eff;
    wire                     at_boundary;
    wire                     wake_now;
    wire [`CIES_NSRC-1:0]    raw_req;
    wire [`CIES_NSRC-1:0]    live_req;
    wire [2:0]               win_idx;
    wire                     accept;
    wire                     start_ret;
    wire                     wr_ctrl;
    wire                     wr_enable;
    wire                     wr_flags;
    wire                     wr_sp;

    assign idle      = (state_reg == `CIES_ST_IDLE);
    assign seq_busy_o = ~idle;

    // bus write decode
    assign wr_ctrl   = reg_wr_i && (reg_addr_i == `CIES_OFF_CTRL);
    assign wr_enable = reg_wr_i && (reg_addr_i == `CIES_OFF_ENABLE);
    assign wr_flags  = reg_wr_i && (reg_addr_i == `CIES_OFF_FLAGS);
    assign wr_sp     = reg_wr_i && (reg_addr_i == `CIES_OFF_SP);

    // disabling instruction blocks the boundary it completes on
    assign cli_now = insn_done_i && insn_cli_i;
    // enabling instruction: the next one must still complete first
    assign sei_now = insn_done_i && insn_sei_i;

    // a bus write of zero to the enable also bites this same cycle
    assign gie_eff = gie_reg && ~cli_now && ~sei_now
                     && ~(wr_ctrl && ~reg_wdata_i[`CIES_CTRL_GIE_BIT]);

    // entry only between whole instructions; every instruction, single
    // cycle alu ones included, reports its completion on insn_done_i
    assign at_boundary = insn_done_i && ~ret_shadow_reg && ~return_from_interrupt_instruction_start_i;
    assign wake_now    = sleep_i && wake_ready_i;

    // flag type sources come from memory, level type straight from pins
    assign raw_req  = (flags_reg & ~`CIES_LEVEL_MASK)
                      | (src_level_i & `CIES_LEVEL_MASK);
    assign live_req = raw_req & enable_reg;
    assign win_idx  = pick_lowest(live_req);

    assign accept    = idle && gie_eff && (|live_req)
                       && (at_boundary || wake_now);
    assign start_ret = idle && return_from_interrupt_instruction_start_i;

    // pending flags: hardware set beats both clears in the same cycle
    always @* begin
        flags_next = flags_reg;
        if (wr_flags) begin
            flags_next = flags_next & ~reg_wdata_i[`CIES_NSRC-1:0];
        end
        if (accept) begin
            flags_next = flags_next & ~onehot(win_idx);
        end
        // event held even while source or global enable is off
        flags_next = (flags_next | src_event_i) & ~`CIES_LEVEL_MASK;
    end

    // pending flag storage
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_reg <= 8'h00;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // per source enables, software owned
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enable_reg <= `CIES_ENABLE_RST;
        end else if (wr_enable) begin
            enable_reg <= reg_wdata_i[`CIES_NSRC-1:0];
        end
    end

    // global enable: entry clears, return sets, instructions and bus
    // write it; the status flags themselves are never stacked here
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gie_reg <= 1'b0;
        end else if (accept) begin
            gie_reg <= 1'b0;
        end else if (state_reg == `CIES_ST_RETURN && cnt_reg == 4'h3) begin
            gie_reg <= 1'b1;
        end else if (cli_now) begin
            gie_reg <= 1'b0;
        end else if (sei_now) begin
            gie_reg <= 1'b1;
        end else if (wr_ctrl) begin
            gie_reg <= reg_wdata_i[`CIES_CTRL_GIE_BIT];
        end
    end

    // after a return the first main instruction boundary is skipped
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ret_shadow_reg <= 1'b0;
        end else if (state_reg == `CIES_ST_RETURN && cnt_reg == 4'h3) begin
            ret_shadow_reg <= 1'b1;
        end else if (insn_done_i) begin
            ret_shadow_reg <= 1'b0;
        end
    end

    // entry and return sequence; single clock, no divider anywhere
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg     <= `CIES_ST_IDLE;
            cnt_reg       <= 4'h0;
            len_reg       <= 4'h0;
            sp_reg        <= `CIES_SP_RST;
            hi_reg        <= 1'b0;
            vec_reg       <= `CIES_RESET_VEC;
            last_src_reg  <= 3'd0;
            stack_we_o    <= 1'b0;
            stack_re_o    <= 1'b0;
            stack_addr_o  <= `CIES_SP_RST;
            stack_wdata_o <= 8'h00;
            pc_load_o     <= 1'b0;
            pc_target_o   <= `CIES_RESET_VEC;
            src_ack_o     <= 8'h00;
        end else begin
            // strobes last one cycle
            stack_we_o <= 1'b0;
            stack_re_o <= 1'b0;
            pc_load_o  <= 1'b0;
            src_ack_o  <= 8'h00;
            case (state_reg)
                `CIES_ST_IDLE: begin
                    if (start_ret) begin
                        // pop high byte first: it was pushed last
                        state_reg    <= `CIES_ST_RETURN;
                        cnt_reg      <= 4'h1;
                        stack_re_o   <= 1'b1;
                        stack_addr_o <= sp_reg + 8'h01;
                        sp_reg       <= sp_reg + 8'h01;
                    end else if (accept) begin
                        // waking adds cycles on top of the oscillator start
                        state_reg     <= `CIES_ST_ENTRY;
                        cnt_reg       <= 4'h1;
                        len_reg       <= wake_now ? (`CIES_ENTRY_CYC + `CIES_SLEEP_EXTRA)
                                                  : `CIES_ENTRY_CYC;
                        vec_reg       <= vector_of(win_idx);
                        last_src_reg  <= win_idx;
                        src_ack_o     <= onehot(win_idx);
                        hi_reg        <= pc_return_i[8];
                        stack_we_o    <= 1'b1;
                        stack_addr_o  <= sp_reg;
                        stack_wdata_o <= pc_return_i[7:0];
                        sp_reg        <= sp_reg - 8'h01;
                    end else if (wr_sp) begin
                        sp_reg <= reg_wdata_i[`CIES_SP_W-1:0];
                    end
                end
                `CIES_ST_ENTRY: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == 4'h1) begin
                        stack_we_o    <= 1'b1;
                        stack_addr_o  <= sp_reg;
                        stack_wdata_o <= {7'h00, hi_reg};
                        sp_reg        <= sp_reg - 8'h01;
                    end
                    if (cnt_reg == len_reg - 4'h1) begin
                        pc_load_o   <= 1'b1;
                        pc_target_o <= vec_reg;
                    end
                    if (cnt_reg == len_reg) begin
                        state_reg <= `CIES_ST_IDLE;
                        cnt_reg   <= 4'h0;
                    end
                end
                `CIES_ST_RETURN: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == 4'h1) begin
                        stack_re_o   <= 1'b1;
                        stack_addr_o <= sp_reg + 8'h01;
                        sp_reg       <= sp_reg + 8'h01;
                    end
                    if (cnt_reg == 4'h2) begin
                        hi_reg <= stack_rdata_i[0];
                    end
                    if (cnt_reg == 4'h3) begin
                        pc_load_o   <= 1'b1;
                        pc_target_o <= {hi_reg, stack_rdata_i};
                    end
                    if (cnt_reg == `CIES_RETURN_CYC) begin
                        state_reg <= `CIES_ST_IDLE;
                        cnt_reg   <= 4'h0;
                    end
                end
                default: begin
                    state_reg <= `CIES_ST_IDLE;
                    cnt_reg   <= 4'h0;
                end
            endcase
        end
    end

    // global enable is visible to the status flags register of the core
    always @* begin
        global_irq_enable_o = gie_reg;
    end

    // read data one cycle after the strobe, zero on unmapped offsets
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `CIES_OFF_CTRL:   reg_rdata_o <= {31'h0000_0000, gie_reg};
                `CIES_OFF_ENABLE: reg_rdata_o <= {24'h00_0000, enable_reg};
                `CIES_OFF_FLAGS:  reg_rdata_o <= {24'h00_0000, flags_reg};
                `CIES_OFF_LEVEL:  reg_rdata_o <= {24'h00_0000, src_level_i & `CIES_LEVEL_MASK};
                `CIES_OFF_SP:     reg_rdata_o <= {24'h00_0000, sp_reg};
                `CIES_OFF_STATUS: reg_rdata_o <= {17'h0_0000, ret_shadow_reg, last_src_reg,
                                                  vec_reg, state_reg};
                default:          reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule

// File: testbench/cies_sequencer_chk.sv
// port-level checks of interrupt entry and return sequencing
`timescale 1ns/1ps
`include "cies_defs.vh"

module cies_sequencer_chk (
    input logic                  core_clk_i,
    input logic                  arst_n_i,
    input logic                  insn_done_i,
    input logic                  insn_sei_i,
    input logic                  insn_cli_i,
    input logic                  sleep_i,
    input logic [`CIES_PC_W-1:0] pc_return_i,
    input logic [`CIES_NSRC-1:0] src_ack_o,
    input logic                  pc_load_o,
    input logic [`CIES_PC_W-1:0] pc_target_o,
    input logic                  global_irq_enable_o,
    input logic                  stack_we_o,
    input logic                  stack_re_o,
    input logic [`CIES_SP_W-1:0] stack_addr_o,
    input logic [7:0]            stack_wdata_o,
    input logic [7:0]            stack_rdata_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [8:0] ack_vec;
    // vector word of the served source, kept combinational so $past can look back at it
    always_comb begin
        ack_vec = 9'h000;
        for (int i = 0; i < 8; i++) if (src_ack_o[i]) ack_vec = 9'(i + 1);
    end
    AST_ACCEPT_GIE: assert property (|src_ack_o |-> !global_irq_enable_o && $past(global_irq_enable_o))
        else $error("entry without enable or enable left set");
    AST_ENTRY_FOUR: assert property (|src_ack_o && !$past(sleep_i) |->
        !pc_load_o [*3] ##1 (pc_load_o && pc_target_o == $past(ack_vec, 3))) else $error("entry timing or vector wrong");
    AST_ENTRY_SLEEP: assert property (|src_ack_o && $past(sleep_i) |->
        ##7 (pc_load_o && pc_target_o == $past(ack_vec, 7))) else $error("wake entry timing wrong");
    AST_PUSH_PC: assert property (|src_ack_o |-> (stack_we_o && stack_wdata_o == $past(pc_return_i[7:0]))
        ##1 (stack_we_o && stack_addr_o == $past(stack_addr_o) - 8'h01 && stack_wdata_o == {7'h00, $past(pc_return_i[8], 2)}))
        else $error("return address push wrong");
    AST_RETURN: assert property (stack_re_o && !$past(stack_re_o) |->
        ##1 (stack_re_o && stack_addr_o == $past(stack_addr_o) + 8'h01) ##2 (pc_load_o && global_irq_enable_o))
        else $error("return sequence wrong");
    AST_RETURN_PC: assert property (pc_load_o && $past(stack_re_o, 3) |->
        pc_target_o == {$past(stack_rdata_i[0], 2), $past(stack_rdata_i)}) else $error("popped address wrong");
    AST_CLI: assert property (insn_done_i && insn_cli_i |=> src_ack_o == 8'h00 && !global_irq_enable_o)
        else $error("entry after global disable");
    AST_SEI: assert property (insn_done_i && insn_sei_i |=> src_ack_o == 8'h00)
        else $error("entry at global enable boundary");
    COV_SLEEP: cover property (|src_ack_o && $past(sleep_i));
    COV_RET: cover property (stack_re_o);
    COV_CLI: cover property (insn_done_i && insn_cli_i);
endmodule

bind cies_sequencer cies_sequencer_chk u_chk (.core_clk_i, .arst_n_i, .insn_done_i, .insn_sei_i, .insn_cli_i, .sleep_i,
    .pc_return_i, .src_ack_o, .pc_load_o, .pc_target_o, .global_irq_enable_o, .stack_we_o, .stack_re_o, .stack_addr_o,
    .stack_wdata_o, .stack_rdata_i);

// File: testbench/cies_stack_mem.sv
// behavioural data memory holding the stack bytes
`timescale 1ns/1ps

module cies_stack_mem (
    input  wire logic       core_clk_i,
    input  wire logic       stack_we_i,
    input  wire logic       stack_re_i,
    input  wire logic [7:0] stack_addr_i,
    input  wire logic [7:0] stack_wdata_i,
    output logic      [7:0] stack_rdata_o
);
    logic [7:0] mem_reg [0:255];
    initial stack_rdata_o = 8'h00;
    // read data stands one cycle only; otherwise it toggles so a stale byte never matches by luck
    always @(posedge core_clk_i) begin
        if (stack_we_i) begin
            mem_reg[stack_addr_i] <= stack_wdata_i;
        end
        stack_rdata_o <= stack_re_i ? mem_reg[stack_addr_i] : ~stack_rdata_o;
    end
endmodule

// File: testbench/cies_sequencer_tb.sv
// self-checking bench for the interrupt entry sequencer
`timescale 1ns/1ps
`include "cies_defs.vh"

module cies_sequencer_tb;
    logic        core_clk_i, arst_n_i, reg_wr_i, reg_rd_i, insn_done_i, insn_sei_i, insn_cli_i, return_from_interrupt_instruction_start_i;
    logic        sleep_i, wake_ready_i, seq_busy_o, pc_load_o, global_irq_enable_o, stack_we_o, stack_re_o;
    logic [7:0]  reg_addr_i, src_event_i, src_level_i, src_ack_o, stack_addr_o, stack_wdata_o, stack_rdata_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    logic [8:0]  pc_return_i, pc_target_o, pc1, pc2;
    int          err_count, checks_done, seed, a, b, n;

    cies_sequencer DUT (.core_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .src_event_i, .src_level_i, .src_ack_o, .insn_done_i, .insn_sei_i, .insn_cli_i, .return_from_interrupt_instruction_start_i, .sleep_i,
        .wake_ready_i, .pc_return_i, .seq_busy_o, .pc_load_o, .pc_target_o, .global_irq_enable_o, .stack_we_o,
        .stack_re_o, .stack_addr_o, .stack_wdata_o, .stack_rdata_i);
    cies_stack_mem u_mem (.core_clk_i, .stack_we_i(stack_we_o), .stack_re_i(stack_re_o), .stack_addr_i(stack_addr_o),
        .stack_wdata_i(stack_wdata_o), .stack_rdata_o(stack_rdata_i));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= ad;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    // read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input string nm);
        @(posedge core_clk_i);
        reg_addr_i <= ad;
        reg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
        #1 chk(nm, reg_rdata_o, exp);
    endtask
    task automatic ev(input logic [7:0] bits);
        @(posedge core_clk_i);
        src_event_i <= bits;
        @(posedge core_clk_i);
        src_event_i <= 8'h00;
    endtask
    // an instruction boundary that must not start an entry
    task automatic bnd(input logic sei, input logic global_irq_disable_instruction);
        @(posedge core_clk_i);
        insn_done_i <= 1'b1;
        insn_sei_i  <= sei;
        insn_cli_i  <= global_irq_disable_instruction;
        @(posedge core_clk_i);
        insn_done_i <= 1'b0;
        insn_sei_i  <= 1'b0;
        insn_cli_i  <= 1'b0;
        #1 chk("no_entry", src_ack_o, 32'h0000_0000);
        chk("idle", seq_busy_o, 32'h0000_0000);
    endtask
    // counts cycles from the accepting edge until the jump pulse
    task automatic wait_load(input int cyc, input logic [8:0] tgt);
        n = 1;
        while (pc_load_o !== 1'b1) begin
            if (n > 20) begin
                err_count++;
                finish_test();
            end
            @(posedge core_clk_i);
            n++;
            #1;
        end
        chk("cycles", n, cyc);
        chk("target", pc_target_o, tgt);
        chk("busy", seq_busy_o, 32'h0000_0001);
    endtask
    // entry at a boundary, or by waking from sleep when cyc is 8
    task automatic enter(input logic [8:0] pc, input int src, input int cyc);
        @(posedge core_clk_i);
        pc_return_i  <= pc;
        insn_done_i  <= (cyc == 4);
        sleep_i      <= (cyc != 4);
        wake_ready_i <= (cyc != 4);
        @(posedge core_clk_i);
        insn_done_i  <= 1'b0;
        sleep_i      <= 1'b0;
        wake_ready_i <= 1'b0;
        pc_return_i  <= ~pc;
        #1 chk("ack", src_ack_o, 32'h0000_0001 << src);
        chk("gie_entry", global_irq_enable_o, 32'h0000_0000);
        wait_load(cyc, 9'(src + 1));
    endtask
    task automatic ret(input logic [8:0] pc);
        @(posedge core_clk_i);
        return_from_interrupt_instruction_start_i <= 1'b1;
        @(posedge core_clk_i);
        return_from_interrupt_instruction_start_i <= 1'b0;
        #1 wait_load(4, pc);
        chk("gie_return", global_irq_enable_o, 32'h0000_0001);
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    initial begin
        {arst_n_i, reg_wr_i, reg_rd_i, insn_done_i, insn_sei_i, insn_cli_i, return_from_interrupt_instruction_start_i, sleep_i, wake_ready_i} = '0;
        {reg_addr_i, src_event_i, src_level_i, reg_wdata_i, pc_return_i} = '0;
        err_count = 0;
        checks_done = 0;
        seed = 32'h0000_ddbe;
        repeat (2) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        rd(`CIES_OFF_SP, 32'h0000_009f, "sp_reset");
        rd(8'h18, 32'h0000_0000, "unmapped");
        // disabled source keeps its flag; zero writes keep, one writes clear
        wr(`CIES_OFF_CTRL, 32'h0000_0001);
        ev(8'h08);
        bnd(1'b0, 1'b0);
        rd(`CIES_OFF_FLAGS, 32'h0000_0008, "flag_held");
        wr(`CIES_OFF_FLAGS, 32'h0000_0000);
        rd(`CIES_OFF_FLAGS, 32'h0000_0008, "flag_zero_write");
        wr(`CIES_OFF_FLAGS, 32'h0000_0008);
        rd(`CIES_OFF_FLAGS, 32'h0000_0000, "flag_cleared");
        wr(`CIES_OFF_ENABLE, 32'h0000_001f);
        ev(8'h01);
        bnd(1'b0, 1'b1);
        bnd(1'b1, 1'b0);
        pc1 = 9'($random(seed));
        enter(pc1, 0, 4);
        rd(`CIES_OFF_SP, 32'h0000_009d, "sp_pushed");
        ret(pc1);
        rd(`CIES_OFF_SP, 32'h0000_009f, "sp_popped");
        // two pending flags: lower one first, then nested or after one main instruction
        for (int i = 0; i < 8; i++) begin
            a   = $unsigned($random(seed)) % 3;
            b   = a + 1 + $unsigned($random(seed)) % (3 - a);
            pc1 = 9'($random(seed));
            pc2 = 9'($random(seed));
            ev(8'(1 << a) | 8'(1 << b));
            bnd(1'b0, 1'b0);
            enter(pc1, a, 4);
            rd(`CIES_OFF_FLAGS, 32'h0000_0001 << b, "flag_left");
            if (i % 2) begin
                wr(`CIES_OFF_CTRL, 32'h0000_0001);
                enter(pc2, b, 4);
                ret(pc2);
                ret(pc1);
            end else begin
                ret(pc1);
                bnd(1'b0, 1'b0);
                enter(pc2, b, 4);
                ret(pc2);
            end
        end
        // a level request that vanishes while disabled is lost
        wr(`CIES_OFF_CTRL, 32'h0000_0000);
        src_level_i <= 8'h10;
        repeat (3) @(posedge core_clk_i);
        rd(`CIES_OFF_LEVEL, 32'h0000_0010, "level_seen");
        src_level_i <= 8'h00;
        wr(`CIES_OFF_CTRL, 32'h0000_0001);
        repeat (2) bnd(1'b0, 1'b0);
        // software moves the stack before the next entry
        wr(`CIES_OFF_SP, 32'h0000_0080);
        @(posedge core_clk_i);
        src_level_i <= 8'h10;
        enter(pc1, 4, 4);
        @(posedge core_clk_i);
        src_level_i <= 8'h00;
        rd(`CIES_OFF_SP, 32'h0000_007e, "sp_moved");
        rd(`CIES_OFF_CTRL, 32'h0000_0000, "gie_cleared");
        ret(pc1);
        // shadow set, last source 4, vector 5, state idle
        rd(`CIES_OFF_STATUS, 32'h0000_6014, "status");
        ev(8'h01);
        // asleep but start-up not finished: entry must wait
        sleep_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 chk("asleep", seq_busy_o, 32'h0000_0000);
        enter(pc2, 0, 8);
        ret(pc2);
        finish_test();
    end
endmodule
